// *** srp_defines.svh ***
// Purpose: constants for the serial port with handshake
// Assumes: 100 MHz hclk, AHB-Lite register access
// Notes: byte offsets are compared on haddr[7:0]
// What this block does
// - act as terminal equipment on the link
// - send characters on the transmit line
// - software flow keeps request-to-send always on
// - hardware flow: request-to-send means room left
// - start a character only while clear-to-send is asserted
// - terminal-ready output low in reset, asserted from the first clock after reset
// - seven or eight data bits
// - odd, even or no parity, both directions
// - stop bit count is selectable
// - programmable bit rate drives all timing
// - serial remote control forces talk-only bus
// - configuration changes act at once
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH
`define SRP_A_CTRL 8'h00
`define SRP_A_BAUD 8'h04
`define SRP_A_TXDATA 8'h08
`define SRP_A_RXDATA 8'h0C
`define SRP_A_STATUS 8'h10
`define SRP_CTRL_CHAR8 0
`define SRP_CTRL_PAR_LO 1
`define SRP_CTRL_PAR_HI 2
`define SRP_CTRL_STOP2 3
`define SRP_CTRL_FLOWSW 4
`define SRP_CTRL_REMOTE 5
`define SRP_ST_TXFULL 0
`define SRP_ST_TXBUSY 1
`define SRP_ST_RXFULL 2
`define SRP_ST_OVR 3
`define SRP_ST_PERR 4
`define SRP_ST_FERR 5
`define SRP_ST_PAUSED 6
`define SRP_ST_CTS 7
`define SRP_CTRL_RST 32'h0000_0001
`define SRP_XON 8'h11
`define SRP_XOFF 8'h13
`define SRP_CLK_HZ 100000000
`define SRP_BAUD_RST 9600
`define SRP_DIV_RST (`SRP_CLK_HZ / `SRP_BAUD_RST - 1)
`endif

// *** srp_partner.sv ***
// Purpose: far-side serial host model for the serial port bench
// Assumes: frame settings are copied in by the bench whenever it reprograms the port
// Notes: the line idles at mark (high) between frames, like a released rs-232 line
`timescale 1ns/1ps
`default_nettype none
module srp_partner (
  input wire logic hclk,
  input wire logic txd,
  output logic rxd,
  output logic cts
);
  int div_p = 7;
  logic char8_p = 1'b1;
  logic [1:0] par_p = 2'b00;
  logic stop2_p = 1'b0;
  logic [7:0] got_q[$];
  int frame_errs = 0;
  logic [7:0] rx_d;

  initial begin
    rxd = 1'b1;
    cts = 1'b1;
  end

  function automatic logic par_of(input logic [7:0] d);
    logic [7:0] m;
    m = char8_p ? d : {1'b0, d[6:0]};
    return (par_p == 2'b01) ? ~^m : ^m;
  endfunction

  // caller enters just after a rising edge; bad flips the parity bit on purpose
  task automatic send(input logic [7:0] d, input logic bad);
    int n;
    n = char8_p ? 8 : 7;
    rxd <= 1'b0;
    repeat (div_p + 1) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (div_p + 1) @(posedge hclk);
    end
    if (par_p == 2'b01 || par_p == 2'b10) begin
      rxd <= par_of(d) ^ bad;
      repeat (div_p + 1) @(posedge hclk);
    end
    rxd <= 1'b1;
    repeat ((stop2_p ? 2 : 1) * (div_p + 1)) @(posedge hclk);
  endtask

  // samples every bit at its middle, so a wrong bit period shows as bad data
  always begin
    @(negedge txd);
    repeat ((div_p + 1) / 2) @(posedge hclk);
    if (txd !== 1'b0) frame_errs++;
    rx_d = 8'h00;
    for (int i = 0; i < (char8_p ? 8 : 7); i++) begin
      repeat (div_p + 1) @(posedge hclk);
      rx_d[i] = txd;
    end
    if (par_p == 2'b01 || par_p == 2'b10) begin
      repeat (div_p + 1) @(posedge hclk);
      if (txd !== par_of(rx_d)) frame_errs++;
    end
    repeat (div_p + 1) @(posedge hclk);
    if (txd !== 1'b1) frame_errs++;
    if (stop2_p) begin
      repeat (div_p + 1) @(posedge hclk);
      if (txd !== 1'b1) frame_errs++;
    end
    got_q.push_back(rx_d);
  end
endmodule
`default_nettype wire

// *** srp_pkg.sv ***
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes: one-hot state codes
package srp_pkg;
  typedef enum logic [4:0] {
    SRP_IDLE = 5'b00001,
    SRP_START = 5'b00010,
    SRP_DATA = 5'b00100,
    SRP_PAR = 5'b01000,
    SRP_STOP = 5'b10000
  } srp_state_e;
  typedef enum logic [1:0] {
    SRP_PAR_NONE = 2'b00,
    SRP_PAR_ODD = 2'b01,
    SRP_PAR_EVEN = 2'b10,
    SRP_PAR_RSVD = 2'b11
  } srp_parity_e;
endpackage

// *** srp_rx.sv ***
// Purpose: serial character receiver
// Assumes: bit period is div+1 clocks, rxd synchronised
// Notes: samples mid-bit; only the first stop bit is checked
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.svh"
module srp_rx (
  input wire logic hclk,
  input wire logic hresetn,
  srp_rx_if.rx rif
);
  srp_pkg::srp_state_e st;
  logic [15:0] cnt;
  logic [2:0] bitn;
  logic [7:0] sh;
  logic par_bad;
  logic tick;
  logic has_par;
  logic [2:0] last_bit;
  logic [7:0] word;
  logic exp_par;
  assign tick = (cnt == 16'h0000);
  assign has_par = (rif.parity == srp_pkg::SRP_PAR_ODD) || (rif.parity == srp_pkg::SRP_PAR_EVEN);
  assign last_bit = rif.char8 ? 3'd7 : 3'd6;
  assign word = rif.char8 ? sh : {1'b0, sh[7:1]};
  assign exp_par = (rif.parity == srp_pkg::SRP_PAR_ODD) ? ~^word : ^word;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= srp_pkg::SRP_IDLE;
      cnt <= 16'h0000;
      bitn <= 3'd0;
      sh <= 8'h00;
      par_bad <= 1'b0;
      rif.valid <= 1'b0;
      rif.data <= 8'h00;
      rif.perr <= 1'b0;
      rif.ferr <= 1'b0;
    end else begin
      rif.valid <= 1'b0;
      if (!tick && st != srp_pkg::SRP_IDLE) begin
        cnt <= cnt - 16'h0001;
      end
      unique case (st)
        srp_pkg::SRP_IDLE: begin
          // half a bit to land in the middle of the start bit
          if (!rif.rxd) begin
            cnt <= {1'b0, rif.div[15:1]};
            st <= srp_pkg::SRP_START;
          end
        end
        srp_pkg::SRP_START: begin
          if (tick) begin
            cnt <= rif.div;
            bitn <= 3'd0;
            par_bad <= 1'b0;
            // a glitch shorter than half a bit is not a start
            st <= rif.rxd ? srp_pkg::SRP_IDLE : srp_pkg::SRP_DATA;
          end
        end
        srp_pkg::SRP_DATA: begin
          if (tick) begin
            sh <= {rif.rxd, sh[7:1]};
            cnt <= rif.div;
            bitn <= bitn + 3'd1;
            if (bitn == last_bit) begin
              st <= has_par ? srp_pkg::SRP_PAR : srp_pkg::SRP_STOP;
            end
          end
        end
        srp_pkg::SRP_PAR: begin
          if (tick) begin
            par_bad <= (rif.rxd != exp_par);
            cnt <= rif.div;
            st <= srp_pkg::SRP_STOP;
          end
        end
        srp_pkg::SRP_STOP: begin
          if (tick) begin
            rif.valid <= 1'b1;
            rif.data <= word;
            rif.perr <= par_bad;
            rif.ferr <= !rif.rxd;
            st <= srp_pkg::SRP_IDLE;
          end
        end
        default: st <= srp_pkg::SRP_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rx_nopar;
    !has_par |-> st != srp_pkg::SRP_PAR;
  endproperty
  a_rx_nopar: assert property (p_rx_nopar) else $error("parity sampled with parity off");
  property p_rx_pulse;
    rif.valid |=> !rif.valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe longer than a cycle");
  c_rx_char: cover property (rif.valid && !rif.perr && !rif.ferr);
endmodule
`default_nettype wire

// *** srp_rx_if.sv ***
// Purpose: link between port core and its receiver
// Assumes: single clock
// Notes: rxd is already synchronised
`timescale 1ns/1ps
`default_nettype none
interface srp_rx_if;
  logic char8;
  srp_pkg::srp_parity_e parity;
  logic [15:0] div;
  logic rxd;
  logic valid;
  logic [7:0] data;
  logic perr;
  logic ferr;
  modport core (output char8, output parity, output div, output rxd,
                input valid, input data, input perr, input ferr);
  modport rx (input char8, input parity, input div, input rxd,
              output valid, output data, output perr, output ferr);
endinterface
`default_nettype wire

// *** srp_top.sv ***
// Purpose: serial port as terminal equipment with flow control
// Assumes: AHB-Lite single word transfers, one clock
// Notes: one-character buffer in each direction
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.svh"
module srp_top #(
  parameter logic [15:0] DIV_RESET = 16'(`SRP_DIV_RST)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  input wire logic cts,
  output logic txd,
  output logic rts,
  output logic dtr,
  output logic talk_only
);
  logic char8;
  srp_pkg::srp_parity_e parity;
  logic stop2;
  logic flow_sw;
  logic remote;
  logic [15:0] baud_div;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic acc;
  logic rd_acc;
  logic pop;
  logic wr_ctrl;
  logic wr_baud;
  logic wr_tx;
  logic wr_stat;
  logic [31:0] rd_mux;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] filt;
  logic rxd_f;
  logic cts_f;
  logic [7:0] rx_buf;
  logic rx_full;
  logic ovr;
  logic perr_f;
  logic ferr_f;
  logic is_ctl;
  logic store;
  logic peer_paused;
  logic send_xoff;
  logic send_xon;
  logic [7:0] tx_buf;
  logic tx_full;
  srp_pkg::srp_state_e tx_st;
  logic [15:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_par;
  logic stop_left;
  logic tx_tick;
  logic has_par;
  logic [2:0] last_bit;
  logic go;
  logic take_xoff;
  logic take_xon;
  logic take_data;
  logic [7:0] next_ch;
  logic [7:0] next_masked;

  srp_rx_if rif();
  srp_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .rif(rif)
  );
  // the receiver reads the live settings
  assign rif.char8 = char8;
  assign rif.parity = parity;
  assign rif.div = baud_div;
  assign rif.rxd = rxd_f;

  // bus: reads answer with no wait, writes land in the data phase
  assign acc = hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;
  assign pop = rd_acc && (haddr[7:0] == `SRP_A_RXDATA);
  assign wr_ctrl = wr_pend && (wr_addr == `SRP_A_CTRL);
  assign wr_baud = wr_pend && (wr_addr == `SRP_A_BAUD);
  assign wr_tx = wr_pend && (wr_addr == `SRP_A_TXDATA);
  assign wr_stat = wr_pend && (wr_addr == `SRP_A_STATUS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      `SRP_A_CTRL: begin
        rd_mux[`SRP_CTRL_CHAR8] = char8;
        rd_mux[`SRP_CTRL_PAR_HI:`SRP_CTRL_PAR_LO] = parity;
        rd_mux[`SRP_CTRL_STOP2] = stop2;
        rd_mux[`SRP_CTRL_FLOWSW] = flow_sw;
        rd_mux[`SRP_CTRL_REMOTE] = remote;
      end
      `SRP_A_BAUD: rd_mux[15:0] = baud_div;
      `SRP_A_RXDATA: rd_mux[7:0] = rx_buf;
      `SRP_A_STATUS: begin
        rd_mux[`SRP_ST_TXFULL] = tx_full;
        rd_mux[`SRP_ST_TXBUSY] = (tx_st != srp_pkg::SRP_IDLE);
        rd_mux[`SRP_ST_RXFULL] = rx_full;
        rd_mux[`SRP_ST_OVR] = ovr;
        rd_mux[`SRP_ST_PERR] = perr_f;
        rd_mux[`SRP_ST_FERR] = ferr_f;
        rd_mux[`SRP_ST_PAUSED] = peer_paused;
        rd_mux[`SRP_ST_CTS] = cts_f;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= acc & hwrite;
      if (acc) begin
        wr_addr <= haddr[7:0];
      end
      if (rd_acc) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      char8 <= 1'(`SRP_CTRL_RST);
      parity <= srp_pkg::SRP_PAR_NONE;
      stop2 <= 1'b0;
      flow_sw <= 1'b0;
      remote <= 1'b0;
      baud_div <= DIV_RESET;
    end else begin
      if (wr_ctrl) begin
        char8 <= hwdata[`SRP_CTRL_CHAR8];
        parity <= srp_pkg::srp_parity_e'(hwdata[`SRP_CTRL_PAR_HI:`SRP_CTRL_PAR_LO]);
        stop2 <= hwdata[`SRP_CTRL_STOP2];
        flow_sw <= hwdata[`SRP_CTRL_FLOWSW];
        remote <= hwdata[`SRP_CTRL_REMOTE];
      end
      if (wr_baud) begin
        baud_div <= hwdata[15:0];
      end
    end
  end

  // pins from the partner: three flops, accept when stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 2'b01;
      s2 <= 2'b01;
      s3 <= 2'b01;
      filt <= 2'b01;
    end else begin
      s1 <= {cts, rxd};
      s2 <= s1;
      s3 <= s2;
      filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    end
  end
  assign rxd_f = filt[0];
  assign cts_f = filt[1];

  // under software flow the partner's Xon/Xoff are consumed, not buffered
  assign is_ctl = flow_sw && ((rif.data == `SRP_XON) || (rif.data == `SRP_XOFF));
  assign store = rif.valid && !is_ctl;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
      ovr <= 1'b0;
      perr_f <= 1'b0;
      ferr_f <= 1'b0;
    end else begin
      // a character arriving while full is dropped and flagged
      if (store && (!rx_full || pop)) begin
        rx_buf <= rif.data;
      end
      rx_full <= store | (rx_full & ~pop);
      // error flags: write one to clear, a new event wins over the clear
      ovr <= (store & rx_full & ~pop) | (ovr & ~(wr_stat & hwdata[`SRP_ST_OVR]));
      perr_f <= (store & rif.perr) | (perr_f & ~(wr_stat & hwdata[`SRP_ST_PERR]));
      ferr_f <= (store & rif.ferr) | (ferr_f & ~(wr_stat & hwdata[`SRP_ST_FERR]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peer_paused <= 1'b0;
      send_xoff <= 1'b0;
      send_xon <= 1'b0;
    end else if (!flow_sw) begin
      peer_paused <= 1'b0;
      send_xoff <= 1'b0;
      send_xon <= 1'b0;
    end else begin
      if (rif.valid && rif.data == `SRP_XOFF) begin
        peer_paused <= 1'b1;
      end else if (rif.valid && rif.data == `SRP_XON) begin
        peer_paused <= 1'b0;
      end
      if (store) begin
        send_xoff <= 1'b1;
        send_xon <= 1'b0;
      end else if (pop && rx_full) begin
        send_xon <= 1'b1;
        send_xoff <= 1'b0;
      end else begin
        send_xoff <= send_xoff & ~take_xoff;
        send_xon <= send_xon & ~take_xon;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
    end else begin
      // a write while the buffer is full is ignored
      if (wr_tx && !tx_full) begin
        tx_buf <= hwdata[7:0];
      end
      tx_full <= (wr_tx & ~tx_full) | (tx_full & ~take_data);
    end
  end

  // flow control characters go ahead of buffered data
  assign go = (tx_st == srp_pkg::SRP_IDLE) && cts_f &&
              (send_xoff || send_xon || (tx_full && !peer_paused));
  assign take_xoff = go && send_xoff;
  assign take_xon = go && !send_xoff && send_xon;
  assign take_data = go && !send_xoff && !send_xon;
  assign next_ch = send_xoff ? `SRP_XOFF : (send_xon ? `SRP_XON : tx_buf);
  assign next_masked = char8 ? next_ch : {1'b0, next_ch[6:0]};
  assign tx_tick = (tx_cnt == 16'h0000);
  assign has_par = (parity == srp_pkg::SRP_PAR_ODD) || (parity == srp_pkg::SRP_PAR_EVEN);
  assign last_bit = char8 ? 3'd7 : 3'd6;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st <= srp_pkg::SRP_IDLE;
      tx_cnt <= 16'h0000;
      tx_bit <= 3'd0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
      stop_left <= 1'b0;
      txd <= 1'b1;
    end else begin
      if (!tx_tick && tx_st != srp_pkg::SRP_IDLE) begin
        tx_cnt <= tx_cnt - 16'h0001;
      end
      unique case (tx_st)
        srp_pkg::SRP_IDLE: begin
          txd <= 1'b1;
          if (go) begin
            tx_st <= srp_pkg::SRP_START;
            txd <= 1'b0;
            tx_cnt <= baud_div;
            tx_sh <= next_masked;
            tx_bit <= 3'd0;
            tx_par <= (parity == srp_pkg::SRP_PAR_ODD) ? ~^next_masked : ^next_masked;
          end
        end
        srp_pkg::SRP_START: begin
          if (tx_tick) begin
            tx_st <= srp_pkg::SRP_DATA;
            txd <= tx_sh[0];
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_cnt <= baud_div;
          end
        end
        srp_pkg::SRP_DATA: begin
          if (tx_tick) begin
            tx_cnt <= baud_div;
            if (tx_bit == last_bit) begin
              tx_st <= has_par ? srp_pkg::SRP_PAR : srp_pkg::SRP_STOP;
              txd <= has_par ? tx_par : 1'b1;
              stop_left <= stop2;
            end else begin
              txd <= tx_sh[0];
              tx_sh <= {1'b0, tx_sh[7:1]};
              tx_bit <= tx_bit + 3'd1;
            end
          end
        end
        srp_pkg::SRP_PAR: begin
          if (tx_tick) begin
            tx_st <= srp_pkg::SRP_STOP;
            txd <= 1'b1;
            tx_cnt <= baud_div;
          end
        end
        srp_pkg::SRP_STOP: begin
          if (tx_tick) begin
            if (stop_left) begin
              stop_left <= 1'b0;
              tx_cnt <= baud_div;
            end else begin
              tx_st <= srp_pkg::SRP_IDLE;
            end
          end
        end
        default: tx_st <= srp_pkg::SRP_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts <= 1'b0;
      dtr <= 1'b0;
      talk_only <= 1'b0;
    end else begin
      rts <= flow_sw | ~rx_full;
      dtr <= 1'b1;
      talk_only <= remote;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_dtr;
    $past(hresetn) |-> dtr;
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready dropped");
  property p_rts_sw;
    flow_sw |=> rts;
  endproperty
  a_rts_sw: assert property (p_rts_sw) else $error("request-to-send low in software flow");
  property p_rts_hw;
    (!flow_sw && rx_full) |=> !rts;
  endproperty
  a_rts_hw: assert property (p_rts_hw) else $error("request-to-send high with buffer full");
  property p_cts;
    (tx_st == srp_pkg::SRP_IDLE && !cts_f) |=> tx_st == srp_pkg::SRP_IDLE;
  endproperty
  a_cts: assert property (p_cts) else $error("frame started without clear-to-send");
  property p_start_low;
    tx_st == srp_pkg::SRP_START |-> !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_stop_high;
    tx_st == srp_pkg::SRP_STOP |-> txd;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
  property p_seven;
    (tx_st == srp_pkg::SRP_DATA && !char8) |-> tx_bit <= 3'd6;
  endproperty
  a_seven: assert property (p_seven) else $error("eighth bit sent in seven-bit mode");
  property p_nopar;
    (!has_par && tx_st == srp_pkg::SRP_DATA) |=> tx_st != srp_pkg::SRP_PAR;
  endproperty
  a_nopar: assert property (p_nopar) else $error("parity bit sent with parity off");
  property p_talk;
    ##1 talk_only == $past(remote);
  endproperty
  a_talk: assert property (p_talk) else $error("talk-only does not follow remote select");
  property p_cnt;
    tx_st != srp_pkg::SRP_IDLE |-> tx_cnt <= baud_div;
  endproperty
  a_cnt: assert property (p_cnt) else $error("bit timer beyond divisor");
  property p_paused;
    (flow_sw && peer_paused && !send_xoff && !send_xon && tx_st == srp_pkg::SRP_IDLE)
      |=> tx_st == srp_pkg::SRP_IDLE;
  endproperty
  a_paused: assert property (p_paused) else $error("data sent while partner paused");
  c_frame: cover property (tx_st == srp_pkg::SRP_IDLE ##1 tx_st == srp_pkg::SRP_START);
  c_xoff: cover property (take_xoff);
  c_ovr: cover property ($rose(ovr));
endmodule
`default_nettype wire

// *** srp_top_bench.sv ***
// Purpose: self-checking bench for the serial port with handshake
// Assumes: single ahb-lite master, one clock, partner model on the serial side
// Notes: a short reset divisor keeps frames to a few clocks per bit
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.svh"
module srp_top_bench;
  localparam logic [15:0] DIV0 = 16'h0007;
  localparam int LIMIT = 50000;
  localparam logic [31:0] CTAB [5] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_000D,
                                       32'h0000_000C, 32'h0000_0007};
  localparam logic [15:0] DTAB [5] = '{16'h0003, 16'h0007, 16'h0005, 16'h000B, 16'h0004};
  localparam logic [7:0] VTAB [5] = '{8'hA5, 8'hC3, 8'h5A, 8'hF0, 8'h81};
  logic hclk, hresetn, hsel, hwrite, rxd, cts, txd, rts, dtr, talk_only, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #5 hclk = ~hclk;

  srp_top #(.DIV_RESET(DIV0)) u_srp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rxd(rxd), .cts(cts), .txd(txd), .rts(rts), .dtr(dtr), .talk_only(talk_only));
  srp_partner u_srp_partner (.hclk(hclk), .txd(txd), .rxd(rxd), .cts(cts));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // polls status until the bit reaches v; the caller compares the final value
  task automatic wait_st(input int b, input logic v);
    for (int k = 0; k < 300; k++) begin
      xfer(1'b0, `SRP_A_STATUS, 32'h0000_0000);
      if (rd[b] === v) break;
    end
  endtask

  task automatic got(input logic [7:0] exp);
    int k;
    for (k = 0; k < 1000 && u_srp_partner.got_q.size() == 0; k++) @(posedge hclk);
    if (u_srp_partner.got_q.size() == 0) check(32'hFFFF_FFFF, {24'h00_0000, exp});
    else check({24'h00_0000, u_srp_partner.got_q.pop_front()}, {24'h00_0000, exp});
  endtask

  // registered pins lag the bus write by an edge or two; look between edges
  task automatic settle;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic cfg(input logic [31:0] c, input logic [15:0] dv);
    xfer(1'b1, `SRP_A_CTRL, c);
    xfer(1'b1, `SRP_A_BAUD, {16'h0000, dv});
    u_srp_partner.char8_p = c[0];
    u_srp_partner.par_p = c[2:1];
    u_srp_partner.stop2_p = c[3];
    u_srp_partner.div_p = int'(dv);
  endtask

  function automatic logic [7:0] fit(input logic [7:0] d, input logic [31:0] c);
    return c[0] ? d : {1'b0, d[6:0]};
  endfunction

  task automatic done_t(input string s);
    $display("test %s done, mismatches so far %0d", s, n_errors);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    check(32'(dtr), 32'h0000_0001);
    check(32'(rts), 32'h0000_0001);
    check({30'h0000_0000, hresp, talk_only}, 32'h0000_0000);
    check(32'(txd), 32'h0000_0001);
    rd_chk(`SRP_A_CTRL, `SRP_CTRL_RST);
    rd_chk(`SRP_A_BAUD, 32'(DIV0));
    rd_chk(`SRP_A_STATUS, 32'h0000_0080);
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0000_0000);
    done_t("reset");
    // every size, parity choice and stop count, each at its own bit rate
    for (int i = 0; i < 5; i++) begin
      cfg(CTAB[i], DTAB[i]);
      xfer(1'b1, `SRP_A_TXDATA, {24'h00_0000, VTAB[i]});
      got(fit(VTAB[i], CTAB[i]));
      u_srp_partner.send(~VTAB[i], 1'b0);
      wait_st(`SRP_ST_RXFULL, 1'b1);
      settle();
      check(32'(rts), 32'h0000_0000);
      rd_chk(`SRP_A_RXDATA, {24'h00_0000, fit(~VTAB[i], CTAB[i])});
      xfer(1'b0, `SRP_A_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_003C, 32'h0000_0000);
      settle();
      check(32'(rts), 32'h0000_0001);
    end
    done_t("formats");
    cfg(32'h0000_0002, DIV0);
    u_srp_partner.send(8'h3C, 1'b1);
    wait_st(`SRP_ST_PERR, 1'b1);
    check(32'(rd[`SRP_ST_PERR]), 32'h0000_0001);
    xfer(1'b1, `SRP_A_STATUS, 32'h0000_0010);
    xfer(1'b0, `SRP_A_RXDATA, 32'h0000_0000);
    xfer(1'b0, `SRP_A_STATUS, 32'h0000_0000);
    check(rd & 32'h0000_0010, 32'h0000_0000);
    done_t("parity error");
    u_srp_partner.send(8'h21, 1'b0);
    u_srp_partner.send(8'h22, 1'b0);
    wait_st(`SRP_ST_OVR, 1'b1);
    check(rd & 32'h0000_000C, 32'h0000_000C);
    check(32'(rts), 32'h0000_0000);
    xfer(1'b1, `SRP_A_STATUS, 32'h0000_0008);
    rd_chk(`SRP_A_RXDATA, 32'h0000_0021);
    xfer(1'b0, `SRP_A_STATUS, 32'h0000_0000);
    check(rd & 32'h0000_000C, 32'h0000_0000);
    done_t("overrun");
    cfg(32'h0000_0001, DIV0);
    u_srp_partner.cts <= 1'b0;
    repeat (6) @(posedge hclk);
    xfer(1'b1, `SRP_A_TXDATA, 32'h0000_0096);
    repeat (200) @(posedge hclk);
    settle();
    check(32'(u_srp_partner.got_q.size()), 32'h0000_0000);
    check(32'(txd), 32'h0000_0001);
    xfer(1'b0, `SRP_A_STATUS, 32'h0000_0000);
    check(rd & 32'h0000_0003, 32'h0000_0001);
    u_srp_partner.cts <= 1'b1;
    got(8'h96);
    done_t("clear to send");
    xfer(1'b1, `SRP_A_CTRL, 32'h0000_0021);
    settle();
    check(32'(talk_only), 32'h0000_0001);
    xfer(1'b1, `SRP_A_CTRL, 32'h0000_0001);
    settle();
    check(32'(talk_only), 32'h0000_0000);
    done_t("remote");
    cfg(32'h0000_0011, DIV0);
    u_srp_partner.send(8'h41, 1'b0);
    wait_st(`SRP_ST_RXFULL, 1'b1);
    settle();
    check(32'(rts), 32'h0000_0001);
    got(`SRP_XOFF);
    rd_chk(`SRP_A_RXDATA, 32'h0000_0041);
    got(`SRP_XON);
    u_srp_partner.send(`SRP_XOFF, 1'b0);
    wait_st(`SRP_ST_PAUSED, 1'b1);
    check(32'(rd[`SRP_ST_PAUSED]), 32'h0000_0001);
    xfer(1'b1, `SRP_A_TXDATA, 32'h0000_0055);
    repeat (200) @(posedge hclk);
    check(32'(u_srp_partner.got_q.size()), 32'h0000_0000);
    u_srp_partner.send(`SRP_XON, 1'b0);
    got(8'h55);
    done_t("software flow");
    check(32'(u_srp_partner.frame_errs), 32'h0000_0000);
    finish_test();
  end
endmodule
`default_nettype wire
